// file: core/smc_pkg.sv
// Package of constants for the stop mode controller
`default_nettype none
package smc_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PWR = 8'h04;
  localparam logic [7:0] ADDR_WAKE = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;
  localparam logic [7:0] ADDR_RA = 8'h10;
  localparam logic [7:0] ADDR_CMD = 8'h14;
  // Control register fields
  localparam int CTRL_STOP_PERMIT = 0;
  localparam int CTRL_VECTOR_MASK = 1;
  localparam int CTRL_DEBUG_EN = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  // Power control fields
  localparam int PWR_LV_EN = 0;
  localparam int PWR_LV_STOP_EN = 1;
  localparam int PWR_INT_REF_STOP = 2;
  localparam int PWR_EXT_CLK_EN = 3;
  localparam int PWR_EXT_STOP_EN = 4;
  localparam int PWR_CONV_ASYNC = 5;
  localparam int PWR_LV_RESET_SEL = 6;
  localparam logic [6:0] PWR_RESET = 7'h00;
  // Wake config fields
  localparam int WAKE_RATE_LSB = 0;
  localparam int WAKE_CLK_SEL = 3;
  localparam int WAKE_SRC_LSB = 4;
  localparam int WAKE_SRC_W = 5;
  localparam logic [8:0] WAKE_RESET = 9'h000;
  // Addresses
  localparam logic [13:0] RESET_PC = 14'h3FFD;
  localparam logic [13:0] VECTOR_PC = 14'h3FF7;
  // Timing, debug status codes and controller states
  localparam int CLK_MHZ = 200;
  localparam int RESTART_NS = 50;
  localparam int RESTART_CYC = (RESTART_NS * CLK_MHZ + 999) / 1000;
  localparam int LPO_HZ = 1000;
  localparam int LPO_DIV = CLK_MHZ * 1000000 / LPO_HZ;
  localparam logic [1:0] DBG_OK = 2'h0;
  localparam logic [1:0] DBG_ERR_STOP = 2'h2;
  typedef enum logic [1:0] {
    SMC_RUN,
    SMC_STOP,
    SMC_RESTART,
    SMC_BACKGROUND
  } smc_state_type;
endpackage : smc_pkg
`default_nettype wire

// file: core/smc_top.sv
// Stop mode controller: entry, wake, clock and regulator gating
`default_nettype none
module smc_top #(
  parameter int LPO_DIV = smc_pkg::LPO_DIV
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Processor side
  input wire logic STOP_EXEC,
  input wire logic [13:0] NEXT_PC,
  output logic PROC_RUN,
  output logic PC_LOAD,
  output logic [13:0] PC_VALUE,
  output logic ILLEGAL_RESET,
  // Wake sources
  input wire logic [4:0] ASYNC_IRQ,
  input wire logic LOW_VOLTAGE,
  input wire logic DEBUG_BACKGROUND,
  input wire logic DEBUG_STATUS_REQ,
  output logic [1:0] DEBUG_STATUS,
  output logic LV_RESET,
  output logic WAKE_TIMER_IRQ,
  // Clock and power controls
  output logic CORE_CLK_EN,
  output logic DEBUG_CLK_EN,
  output logic INT_CLK_GEN_ON,
  output logic SLOW_OSC_ON,
  output logic EXT_REF_ON,
  output logic CRYSTAL_ON,
  output logic CONV_ACTIVE,
  output logic REG_FULL_ON
);
  smc_pkg::smc_state_type state_q, state_d;
  logic [2:0] ctrl_q;
  logic [6:0] pwr_q;
  logic [8:0] wake_q;
  logic [13:0] ret_addr_q;
  logic [31:0] prdata_q;
  logic [7:0] restart_q;
  logic [31:0] lpo_q;
  logic [7:0] rti_q;
  logic pc_load_q;
  logic [13:0] pc_value_q;
  logic illegal_q;
  logic [1:0] dbg_status_q;
  logic lv_reset_q;
  logic rti_flag_q;

  wire stopped = (state_q == smc_pkg::SMC_STOP);
  wire lv_both = pwr_q[smc_pkg::PWR_LV_EN] & pwr_q[smc_pkg::PWR_LV_STOP_EN];
  wire dbg_en = ctrl_q[smc_pkg::CTRL_DEBUG_EN];
  wire wr = PSEL & PENABLE & PWRITE;
  wire [2:0] rate = wake_q[smc_pkg::WAKE_RATE_LSB +: 3];
  wire rti_on = (rate != 3'h0);
  wire slow_osc_en = ~(stopped & ~pwr_q[smc_pkg::PWR_LV_EN] & wake_q[smc_pkg::WAKE_CLK_SEL]);
  wire ext_ok = pwr_q[smc_pkg::PWR_EXT_CLK_EN] & pwr_q[smc_pkg::PWR_EXT_STOP_EN];
  wire lpo_tick = (lpo_q == LPO_DIV - 1);
  wire rti_due = rti_on & lpo_tick & (rti_q == ({5'h00, rate} << rate) - 8'h01);
  wire [4:0] irq_hit = ASYNC_IRQ & wake_q[smc_pkg::WAKE_SRC_LSB +: smc_pkg::WAKE_SRC_W];
  wire lv_irq = LOW_VOLTAGE & lv_both & ~pwr_q[smc_pkg::PWR_LV_RESET_SEL];
  wire wake_irq = (|irq_hit) | lv_irq | rti_flag_q;
  wire start_stop = (state_q == smc_pkg::SMC_RUN) & STOP_EXEC;

  always_comb begin
    state_d = state_q;
    case (state_q)
      smc_pkg::SMC_RUN: begin
        if (start_stop & ctrl_q[smc_pkg::CTRL_STOP_PERMIT]) state_d = smc_pkg::SMC_STOP;
      end
      smc_pkg::SMC_STOP: begin
        if (dbg_en & DEBUG_BACKGROUND) state_d = smc_pkg::SMC_BACKGROUND;
        else if (wake_irq) state_d = smc_pkg::SMC_RESTART;
      end
      smc_pkg::SMC_RESTART: begin
        if (restart_q == 8'(smc_pkg::RESTART_CYC - 1)) state_d = smc_pkg::SMC_RUN;
      end
      smc_pkg::SMC_BACKGROUND: state_d = smc_pkg::SMC_BACKGROUND;
      default: state_d = smc_pkg::SMC_RUN;
    endcase
  end

  // Reset wake restarts at the reset address through the reset branch
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      state_q <= smc_pkg::SMC_RUN;
      restart_q <= 8'h00;
      pc_load_q <= 1'b1;
      pc_value_q <= smc_pkg::RESET_PC;
    end else begin
      state_q <= state_d;
      restart_q <= (state_q == smc_pkg::SMC_RESTART) ? restart_q + 8'h01 : 8'h00;
      pc_load_q <= 1'b0;
      if ((state_q == smc_pkg::SMC_RESTART) && (state_d == smc_pkg::SMC_RUN)
          && !ctrl_q[smc_pkg::CTRL_VECTOR_MASK]) begin
        pc_load_q <= 1'b1;
        pc_value_q <= smc_pkg::VECTOR_PC;
      end
    end
  end

  // Control, power and wake registers are only written by the bus, so stopping leaves them intact
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ctrl_q <= smc_pkg::CTRL_RESET;
      pwr_q <= smc_pkg::PWR_RESET;
      wake_q <= smc_pkg::WAKE_RESET;
      ret_addr_q <= 14'h0000;
      illegal_q <= 1'b0;
    end else begin
      if (wr && PADDR == smc_pkg::ADDR_CTRL) ctrl_q <= PWDATA[2:0];
      if (wr && PADDR == smc_pkg::ADDR_PWR) pwr_q <= PWDATA[6:0];
      if (wr && PADDR == smc_pkg::ADDR_WAKE) wake_q <= PWDATA[8:0];
      if (start_stop) ret_addr_q <= NEXT_PC;
      illegal_q <= start_stop & ~ctrl_q[smc_pkg::CTRL_STOP_PERMIT];
    end
  end

  // Wake timer divides the system clock to a 1 kHz tick; keeps counting in stop unless PWR_LV_EN is clear and WAKE_CLK_SEL is set
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      lpo_q <= 32'h0000_0000;
      rti_q <= 8'h00;
      rti_flag_q <= 1'b0;
    end else begin
      lpo_q <= (lpo_tick || !slow_osc_en) ? 32'h0000_0000 : lpo_q + 32'h0000_0001;
      if (!rti_on) rti_q <= 8'h00;
      else if (lpo_tick) rti_q <= rti_due ? 8'h00 : rti_q + 8'h01;
      if (rti_due) rti_flag_q <= 1'b1;
      else if (state_q == smc_pkg::SMC_RESTART) rti_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      dbg_status_q <= smc_pkg::DBG_OK;
      lv_reset_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      if (DEBUG_STATUS_REQ) dbg_status_q <= stopped ? smc_pkg::DBG_ERR_STOP : smc_pkg::DBG_OK;
      lv_reset_q <= LOW_VOLTAGE & pwr_q[smc_pkg::PWR_LV_RESET_SEL]
                    & (~stopped | lv_both);
      if (PSEL && !PENABLE && !PWRITE) begin
        case (PADDR)
          smc_pkg::ADDR_CTRL: prdata_q <= {29'h0, ctrl_q};
          smc_pkg::ADDR_PWR: prdata_q <= {25'h0, pwr_q};
          smc_pkg::ADDR_WAKE: prdata_q <= {23'h0, wake_q};
          smc_pkg::ADDR_STAT: prdata_q <= {28'h0, rti_flag_q, illegal_q, 2'(state_q)};
          smc_pkg::ADDR_RA: prdata_q <= {18'h0, ret_addr_q};
          default: prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  wire addr_ok = (PADDR == smc_pkg::ADDR_CTRL) | (PADDR == smc_pkg::ADDR_PWR)
               | (PADDR == smc_pkg::ADDR_WAKE) | (PADDR == smc_pkg::ADDR_STAT)
               | (PADDR == smc_pkg::ADDR_RA);
  assign PRDATA = prdata_q;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~addr_ok;
  assign PROC_RUN = (state_q == smc_pkg::SMC_RUN);
  assign PC_LOAD = pc_load_q;
  assign PC_VALUE = pc_value_q;
  assign ILLEGAL_RESET = illegal_q;
  assign DEBUG_STATUS = dbg_status_q;
  assign LV_RESET = lv_reset_q;
  assign WAKE_TIMER_IRQ = rti_flag_q;
  assign CORE_CLK_EN = ~stopped;
  assign DEBUG_CLK_EN = ~stopped | dbg_en;
  assign INT_CLK_GEN_ON = ~stopped | dbg_en
                        | (pwr_q[smc_pkg::PWR_INT_REF_STOP] & lv_both);
  assign SLOW_OSC_ON = slow_osc_en;
  assign EXT_REF_ON = pwr_q[smc_pkg::PWR_EXT_CLK_EN] & (~stopped | ext_ok);
  assign CRYSTAL_ON = pwr_q[smc_pkg::PWR_EXT_CLK_EN] & (~stopped | (ext_ok & lv_both));
  assign CONV_ACTIVE = ~stopped | (pwr_q[smc_pkg::PWR_CONV_ASYNC] & lv_both);
  assign REG_FULL_ON = ~stopped | dbg_en | lv_both;

  a_stop_entry: assert property (@(posedge CLK_SYS) disable iff (RST)
    start_stop & ctrl_q[0] |=> !CORE_CLK_EN) else $error("stop not entered");
  a_illegal_reset: assert property (@(posedge CLK_SYS) disable iff (RST)
    start_stop & !ctrl_q[0] |=> ILLEGAL_RESET && PROC_RUN) else $error("no illegal reset");
  a_reg_hold: assert property (@(posedge CLK_SYS) disable iff (RST)
    stopped & !wr |=> $stable(ctrl_q) && $stable(pwr_q)) else $error("state lost");
  a_reg_standby: assert property (@(posedge CLK_SYS) disable iff (RST)
    stopped & !dbg_en & !lv_both |-> !REG_FULL_ON) else $error("regulator on");
  a_wake_bound: assert property (@(posedge CLK_SYS) disable iff (RST)
    stopped & wake_irq & !DEBUG_BACKGROUND |=> ##[1:20] PROC_RUN) else $error("no wake");
  a_vector_pc: assert property (@(posedge CLK_SYS) disable iff (RST)
    PC_LOAD |-> PC_VALUE == smc_pkg::VECTOR_PC || PC_VALUE == smc_pkg::RESET_PC) else $error("bad pc");
  a_dbg_status: assert property (@(posedge CLK_SYS) disable iff (RST)
    DEBUG_STATUS_REQ & stopped |=> DEBUG_STATUS == smc_pkg::DBG_ERR_STOP) else $error("status");
  a_debug_clock: assert property (@(posedge CLK_SYS) disable iff (RST)
    dbg_en |-> DEBUG_CLK_EN && REG_FULL_ON) else $error("debug clock off");
  a_rate_off: assert property (@(posedge CLK_SYS) disable iff (RST)
    rate == 3'h0 |-> !rti_due) else $error("timer ran");
endmodule : smc_top
`default_nettype wire

// file: test/smc_wake_model.sv
// Wake sources and debug host facing the stop mode controller
`default_nettype none
module smc_wake_model (
  // Clock
  input wire logic clk,
  // Wake and debug lines
  output logic [4:0] irq,
  output logic low_voltage,
  output logic background,
  output logic status_req
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    irq = 5'h0_0;
    low_voltage = 1'b0;
    background = 1'b0;
    status_req = 1'b0;
  end
  // Sources hold their request as a level until serviced
  task automatic set_irq(input logic [4:0] v);
    @(posedge clk);
    irq <= v;
  endtask : set_irq
  // Only sent to a target whose debug mode is enabled
  task automatic send_background();
    @(posedge clk);
    background <= 1'b1;
    @(posedge clk);
    background <= 1'b0;
  endtask : send_background
  // Detector output is a level that stays until the supply recovers
  task automatic set_low_voltage(input logic v);
    @(posedge clk);
    low_voltage <= v;
  endtask : set_low_voltage
  task automatic send_status_req();
    @(posedge clk);
    status_req <= 1'b1;
    @(posedge clk);
    status_req <= 1'b0;
  endtask : send_status_req
endmodule : smc_wake_model
`default_nettype wire

// file: test/stop_mode_controller_test.sv
// Self-checking bench for the stop mode controller
`default_nettype none
module stop_mode_controller_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic stop_exec = 1'b0;
  logic [13:0] next_pc = 14'h0000;
  logic [31:0] prdata, rd;
  logic [13:0] pc_value;
  logic [4:0] async_irq;
  logic [1:0] debug_status;
  logic pready, pslverr, proc_run, pc_load, illegal_reset, lv_reset, timer_irq, low_voltage;
  logic bg, stat_req, core_en, dbg_en, icg_on, slow_on, ext_on, xtal_on, conv_on, reg_on;
  int miscompares = 0;
  int samples_checked = 0;
  int cnt;
  always #2.5 clk_sys = ~clk_sys;
  smc_top #(.LPO_DIV(10)) u_dut (
    .CLK_SYS(clk_sys), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .STOP_EXEC(stop_exec), .NEXT_PC(next_pc), .PROC_RUN(proc_run), .PC_LOAD(pc_load),
    .PC_VALUE(pc_value), .ILLEGAL_RESET(illegal_reset), .ASYNC_IRQ(async_irq),
    .LOW_VOLTAGE(low_voltage), .DEBUG_BACKGROUND(bg), .DEBUG_STATUS_REQ(stat_req),
    .DEBUG_STATUS(debug_status), .LV_RESET(lv_reset), .WAKE_TIMER_IRQ(timer_irq),
    .CORE_CLK_EN(core_en), .DEBUG_CLK_EN(dbg_en), .INT_CLK_GEN_ON(icg_on),
    .SLOW_OSC_ON(slow_on), .EXT_REF_ON(ext_on), .CRYSTAL_ON(xtal_on),
    .CONV_ACTIVE(conv_on), .REG_FULL_ON(reg_on));
  smc_wake_model u_model (.clk(clk_sys), .irq(async_irq), .low_voltage(low_voltage),
    .background(bg), .status_req(stat_req));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) miscompares++;
    rd = prdata;
    check(32'(pslverr), 32'(a > smc_pkg::ADDR_RA));
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic do_stop(input logic [13:0] pc);
    @(posedge clk_sys);
    stop_exec <= 1'b1;
    next_pc <= pc;
    @(posedge clk_sys);
    stop_exec <= 1'b0;
    #1;
  endtask : do_stop
  // Bounded wait for the processor to run again
  task automatic wait_run(input int lim);
    cnt = 0;
    do begin
      @(posedge clk_sys);
      #1;
      cnt++;
    end while (proc_run !== 1'b1 && cnt < lim);
  endtask : wait_run
  task automatic t_reset();
    check(32'(pc_load), 32'h0000_0001);
    check(32'(pc_value), 32'(smc_pkg::RESET_PC));
    rst <= 1'b0;
    apb(smc_pkg::ADDR_CTRL, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    apb(8'h20, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    do_stop(14'h0123);
    check(32'(illegal_reset), 32'h0000_0001);
    check(32'(core_en), 32'h0000_0001);
    $display("reset and refused stop done");
  endtask : t_reset
  task automatic t_vector();
    apb(smc_pkg::ADDR_WAKE, 1'b1, 32'h0000_0010);
    apb(smc_pkg::ADDR_CTRL, 1'b1, 32'h0000_0001);
    do_stop(14'h0456);
    check({core_en, icg_on, reg_on, xtal_on, ext_on, conv_on}, 0);
    u_model.set_irq(5'h0_2);
    repeat (30) @(posedge clk_sys);
    #1 check(32'(proc_run), 32'h0000_0000);
    apb(smc_pkg::ADDR_CTRL, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0001);
    u_model.set_irq(5'h0_3);
    wait_run(40);
    check(32'(cnt >= smc_pkg::RESTART_CYC), 32'h0000_0001);
    check({pc_load, pc_value}, {1'b1, smc_pkg::VECTOR_PC});
    u_model.set_irq(5'h0_0);
    apb(smc_pkg::ADDR_RA, 1'b0, 32'h0000_0000);
    check(rd, 32'h0000_0456);
    $display("vectored wake done");
  endtask : t_vector
  task automatic t_timer();
    apb(smc_pkg::ADDR_PWR, 1'b1, 32'h0000_0018);
    apb(smc_pkg::ADDR_WAKE, 1'b1, 32'h0000_0008);
    apb(smc_pkg::ADDR_CTRL, 1'b1, 32'h0000_0003);
    do_stop(14'h0789);
    check({slow_on, ext_on, xtal_on}, 32'h0000_0002);
    repeat (60) @(posedge clk_sys);
    #1 check(32'(proc_run), 32'h0000_0000);
    apb(smc_pkg::ADDR_WAKE, 1'b1, 32'h0000_0001);
    wait_run(300);
    check({proc_run, pc_load}, 32'h0000_0002);
    // Stop the timer before its sticky flag sets again and wakes the next stop early
    apb(smc_pkg::ADDR_WAKE, 1'b1, 32'h0000_0000);
    check(32'(timer_irq), 32'h0000_0000);
    $display("timer wake done");
  endtask : t_timer
  task automatic t_debug();
    apb(smc_pkg::ADDR_PWR, 1'b1, 32'h0000_0027);
    apb(smc_pkg::ADDR_CTRL, 1'b1, 32'h0000_0005);
    do_stop(14'h0abc);
    check({core_en, dbg_en, reg_on, icg_on, conv_on}, 32'h0000_000f);
    u_model.send_status_req();
    #1 check(32'(debug_status), 32'(smc_pkg::DBG_ERR_STOP));
    u_model.send_background();
    apb(smc_pkg::ADDR_STAT, 1'b0, 32'h0000_0000);
    check(32'(rd[1:0]), 32'(smc_pkg::SMC_BACKGROUND));
    @(posedge clk_sys);
    rst <= 1'b1;
    @(posedge clk_sys);
    #1 check({pc_load, pc_value}, {1'b1, smc_pkg::RESET_PC});
    rst <= 1'b0;
    apb(smc_pkg::ADDR_PWR, 1'b1, 32'h0000_0040);
    u_model.set_low_voltage(1'b1);
    @(posedge clk_sys);
    #1 check(32'(lv_reset), 32'h0000_0001);
    u_model.set_low_voltage(1'b0);
    $display("debug stop done");
  endtask : t_debug
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (12) @(posedge clk_sys);
    t_reset();
    t_vector();
    t_timer();
    t_debug();
    end_sim();
  end
  // Whole run needs a few hundred cycles; this cuts a hang short
  initial begin
    #50000;
    miscompares++;
    end_sim();
  end
endmodule : stop_mode_controller_test
`default_nettype wire
